// File: verilog/rmf_pkg.sv
`default_nettype none
package rmf_pkg;
  // Header and part-header byte counts; the layout is frozen within major version 2
  localparam int unsigned HDR_BYTES = 20;
  localparam int unsigned PHDR_BYTES = 4;
  localparam logic [7:0] PROTO_ID_0 = 8'h52;
  localparam logic [7:0] PROTO_ID_1 = 8'h54;
  localparam logic [7:0] PROTO_ID_2 = 8'h50;
  localparam logic [7:0] PROTO_ID_3 = 8'h53;
  localparam logic [7:0] VERSION_MAJOR = 8'h02;
  localparam logic [7:0] VERSION_MINOR = 8'h02;
  localparam logic [15:0] UNKNOWN_VENDOR_CODE = 16'h0000;
  // Kind code ranges: known set, protocol extensions, vendor-specific
  localparam logic [7:0] KIND_PAD = 8'h01;
  localparam logic [7:0] KIND_KNOWN_LAST = 8'h16;
  localparam logic [7:0] KIND_VENDOR_FIRST = 8'h80;
  localparam logic [15:0] LEN_RESET = 16'h0000;

  typedef struct packed {
    logic [7:0] major;
    logic [7:0] minor;
  } rmf_version_t;

  typedef struct packed {
    logic [7:0] data;
    logic sop;
    logic eop;
  } rmf_beat_t;

  typedef struct packed {
    logic [7:0] kind;
    logic [7:0] flags;
    logic little_endian;
    logic known;
    logic vendor;
    logic last;
    logic [15:0] length;
    logic [31:0] start_offset;
    logic [31:0] body_length;
  } rmf_part_t;

  typedef enum logic [2:0] {
    RMF_IDLE = 3'b000,
    RMF_HDR = 3'b001,
    RMF_PHDR = 3'b011,
    RMF_BODY = 3'b010,
    RMF_DROP = 3'b110
  } rmf_state_t;
endpackage
`default_nettype wire

// File: verilog/rmf_kind_decode.sv
`default_nettype none
module rmf_kind_decode
  import rmf_pkg::*;
(
  // Part header fields
  input wire logic [7:0] kind,
  input wire logic [7:0] flags,
  input wire logic [15:0] implementer_code,
  // Decoded view
  output logic known,
  output logic vendor,
  output logic skip,
  output logic [6:0] kind_flags
);
  always_comb begin
    known = (kind != 8'h00) && (kind <= KIND_KNOWN_LAST);
    vendor = kind >= KIND_VENDOR_FIRST;
    // Vendor parts from an unknown implementer are never interpreted
    skip = !known || (vendor && implementer_code == UNKNOWN_VENDOR_CODE) || kind == KIND_PAD;
    // Flags 1..7 only mean something once the kind is known
    kind_flags = known ? flags[7:1] : 7'h00;
  end
endmodule
`default_nettype wire

// File: verilog/rmf_framer.sv
// What this block does
// - Fixed header comes first; parts are parsed only after it.
// - Header fields in order: identifier, version, implementer code, id prefix.
// - Transmitted version is 2.2.
// - Implementer code names middleware maker; unknown value is accepted.
// - Prefix joins entity suffixes to form full identifiers.
// - Header and part header layouts are hard-wired.
// - Each part is a part header then elements; any number of parts.
// - Part header holds kind, eight flags, sixteen-bit length.
// - Flag 0 selects byte order: clear big, set little.
// - Other flags decode by kind.
// - Length excludes the part header.
// - Nonzero length locates next part header after the body.
// - Total length tells a final part from a non-final one.
// - Zero length means last part, reaching message end.
// - Total length comes from the transport, never the message.
// - Unknown kind codes are tolerated.
// - Kind space keeps extension and vendor ranges.
// - Unknown-kind part is skipped; parsing resumes after it.
// - A valid length always locates the next part.
// - Truncated part header makes the rest invalid and discarded.
`default_nettype none
module rmf_framer
  import rmf_pkg::*;
#(
  parameter int LEN_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Incoming message bytes
  input wire logic in_valid,
  input wire rmf_beat_t in_beat,
  input wire logic [LEN_W-1:0] total_length,
  // Header results
  output logic hdr_valid,
  output logic hdr_bad,
  output rmf_version_t source_version,
  output logic [15:0] implementer_code,
  output logic [95:0] default_id_prefix,
  // Part results
  output logic part_valid,
  output rmf_part_t part_info,
  output logic [6:0] part_kind_flags,
  output logic part_skip,
  output logic body_valid,
  output logic [7:0] body_data,
  // Full identifier build
  input wire logic [31:0] entity_suffix,
  output logic [127:0] full_id,
  // Message status
  output logic msg_done,
  output logic msg_invalid,
  // Send side header source
  output rmf_version_t current_protocol_version
);
  ////////////////////////////////////////////////////////////////////////////
  rmf_state_t state;
  logic [LEN_W-1:0] msg_len;
  logic [LEN_W-1:0] pos;
  logic [LEN_W-1:0] body_left;
  logic [4:0] idx;
  logic [23:0] phdr;
  logic [7:0] hdr_byte [HDR_BYTES];
  logic [LEN_W-1:0] remain;
  logic [LEN_W-1:0] after_hdr;
  logic dec_known;
  logic dec_vendor;
  logic dec_skip;
  logic [6:0] dec_flags;
  logic [15:0] next_len;
  logic [7:0] next_flags;
  logic start;
  logic take;

  assign current_protocol_version = '{major: VERSION_MAJOR, minor: VERSION_MINOR};
  assign start = in_valid && in_beat.sop;
  assign take = in_valid && !in_beat.sop;
  assign remain = msg_len - pos - LEN_W'(1);
  // At the last part header byte phdr holds kind, flags and the first length byte
  assign next_flags = phdr[15:8];
  // Length field follows the byte order of its own part
  assign next_len = next_flags[0] ? {in_beat.data, phdr[7:0]} : {phdr[7:0], in_beat.data};
  assign after_hdr = remain;
  assign full_id = {default_id_prefix, entity_suffix};

  rmf_kind_decode u_dec (
    .kind(phdr[23:16]),
    .flags(next_flags),
    .implementer_code(implementer_code),
    .known(dec_known),
    .vendor(dec_vendor),
    .skip(dec_skip),
    .kind_flags(dec_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Byte position within the message; the transport supplies the length
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos <= '0;
      msg_len <= '0;
    end else if (start) begin
      // Sop is byte 0, so pos always names the byte being taken
      pos <= LEN_W'(1);
      msg_len <= total_length;
    end else if (take) begin
      pos <= pos + LEN_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Framing walk
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= RMF_IDLE;
      idx <= '0;
      body_left <= '0;
      phdr <= '0;
    end else if (start) begin
      // A short message is flagged msg_invalid at its end; hdr_bad stays low
      state <= RMF_HDR;
      idx <= 5'h01;
      phdr <= {16'h0000, in_beat.data};
    end else if (take) begin
      unique case (state)
        RMF_IDLE: state <= RMF_IDLE;
        RMF_HDR: begin
          idx <= idx + 5'h01;
          if (idx == 5'(HDR_BYTES - 1)) begin
            state <= hdr_ok_next() ? RMF_PHDR : RMF_DROP;
            idx <= '0;
          end
        end
        RMF_PHDR: begin
          phdr <= {phdr[15:0], in_beat.data};
          idx <= idx + 5'h01;
          if (idx == 5'(PHDR_BYTES - 1)) begin
            idx <= '0;
            if (next_len == 16'h0000 || LEN_W'(next_len) == after_hdr) begin
              body_left <= after_hdr;
              state <= (after_hdr == '0) ? RMF_IDLE : RMF_BODY;
            end else if (LEN_W'(next_len) > after_hdr) begin
              state <= RMF_DROP;
            end else begin
              body_left <= LEN_W'(next_len);
              state <= (next_len == 16'h0000) ? RMF_PHDR : RMF_BODY;
            end
          end
        end
        RMF_BODY: begin
          body_left <= body_left - LEN_W'(1);
          if (body_left == LEN_W'(1)) begin
            state <= (remain == '0) ? RMF_IDLE : RMF_PHDR;
          end
        end
        RMF_DROP: state <= RMF_DROP;
        default: state <= RMF_IDLE;
      endcase
      if (in_beat.eop) begin
        state <= RMF_IDLE;
      end
    end
  end

  function automatic logic hdr_ok_next();
    logic ok;
    ok = hdr_byte[0] == PROTO_ID_0 && hdr_byte[1] == PROTO_ID_1 &&
         hdr_byte[2] == PROTO_ID_2 && hdr_byte[3] == PROTO_ID_3;
    // Same major version means the layout is known; any implementer code is fine
    ok = ok && hdr_byte[4] == VERSION_MAJOR;
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Header byte capture, fields in fixed order
  for (genvar g = 0; g < HDR_BYTES; g++) begin : g_hdr
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        hdr_byte[g] <= 8'h00;
      end else if (start && g == 0) begin
        hdr_byte[g] <= in_beat.data;
      end else if (take && state == RMF_HDR && idx == 5'(g)) begin
        hdr_byte[g] <= in_beat.data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hdr_valid <= 1'b0;
      hdr_bad <= 1'b0;
      source_version <= '{major: VERSION_MAJOR, minor: VERSION_MINOR};
      implementer_code <= UNKNOWN_VENDOR_CODE;
      default_id_prefix <= '0;
    end else begin
      hdr_valid <= 1'b0;
      hdr_bad <= 1'b0;
      if (start) begin
        // Receiver context restarts for each message
        source_version <= '{major: VERSION_MAJOR, minor: VERSION_MINOR};
        implementer_code <= UNKNOWN_VENDOR_CODE;
        default_id_prefix <= '0;
      end else if (take && state == RMF_HDR && idx == 5'(HDR_BYTES - 1)) begin
        hdr_valid <= hdr_ok_next();
        hdr_bad <= !hdr_ok_next();
        if (hdr_ok_next()) begin
          source_version <= '{major: hdr_byte[4], minor: hdr_byte[5]};
          implementer_code <= {hdr_byte[6], hdr_byte[7]};
          default_id_prefix <= {hdr_byte[8], hdr_byte[9], hdr_byte[10], hdr_byte[11],
                                hdr_byte[12], hdr_byte[13], hdr_byte[14], hdr_byte[15],
                                hdr_byte[16], hdr_byte[17], hdr_byte[18], in_beat.data};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Part descriptors and body bytes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      part_valid <= 1'b0;
      part_info <= '0;
      part_kind_flags <= '0;
      part_skip <= 1'b0;
    end else begin
      part_valid <= 1'b0;
      if (take && state == RMF_PHDR && idx == 5'(PHDR_BYTES - 1) && LEN_W'(next_len) <= after_hdr) begin
        part_valid <= 1'b1;
        // Kind passes through even when unknown; the sink decides with part_skip
        part_info.kind <= phdr[23:16];
        part_info.flags <= phdr[15:8];
        part_info.little_endian <= phdr[8];
        part_info.known <= dec_known;
        part_info.vendor <= dec_vendor;
        part_info.last <= next_len == 16'h0000 || LEN_W'(next_len) == after_hdr;
        part_info.length <= next_len;
        part_info.start_offset <= 32'(pos + LEN_W'(1));
        part_info.body_length <= 32'(next_len == 16'h0000 ? after_hdr : LEN_W'(next_len));
        part_kind_flags <= dec_flags;
        part_skip <= dec_skip;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      body_valid <= 1'b0;
      body_data <= 8'h00;
    end else begin
      // Skipped parts are still walked but their bytes are not delivered
      body_valid <= take && state == RMF_BODY && !part_skip;
      body_data <= in_beat.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // End of message
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msg_done <= 1'b0;
      msg_invalid <= 1'b0;
    end else begin
      msg_done <= take && in_beat.eop;
      if (start) begin
        msg_invalid <= 1'b0;
      end else if (take && in_beat.eop && (state == RMF_HDR || state == RMF_DROP)) begin
        msg_invalid <= 1'b1;
      end else if (take && in_beat.eop && state == RMF_PHDR && idx != 5'(PHDR_BYTES - 1)) begin
        msg_invalid <= 1'b1;
      end else if (take && state == RMF_PHDR && idx == 5'(PHDR_BYTES - 1) && LEN_W'(next_len) > after_hdr) begin
        msg_invalid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/rmf_framer_properties.sv
`default_nettype none
module rmf_framer_chk
  import rmf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Stream in
  input wire logic in_valid,
  input wire rmf_beat_t in_beat,
  input wire logic [31:0] entity_suffix,
  // Results
  input wire logic hdr_valid,
  input wire logic hdr_bad,
  input wire logic [95:0] default_id_prefix,
  input wire logic [127:0] full_id,
  input wire logic part_valid,
  input wire rmf_part_t part_info,
  input wire logic [6:0] part_kind_flags,
  input wire logic body_valid,
  input wire logic msg_done,
  input wire logic msg_invalid,
  input wire rmf_version_t current_protocol_version
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_hdr; (hdr_valid || hdr_bad) |-> $past(in_valid) && !(hdr_valid && hdr_bad); endproperty
  property p_ver; current_protocol_version == {VERSION_MAJOR, VERSION_MINOR}; endproperty
  property p_id; full_id == {default_id_prefix, entity_suffix}; endproperty
  property p_le; part_valid |-> part_info.little_endian == part_info.flags[0]; endproperty
  property p_kf; part_valid |-> part_kind_flags == (part_info.known ? part_info.flags[7:1] : 7'h00); endproperty
  property p_last; part_valid && part_info.length == 16'h0000 |-> part_info.last; endproperty
  property p_next; part_valid && !part_info.last |-> part_info.body_length == 32'(part_info.length); endproperty
  property p_body; body_valid |-> $past(in_valid); endproperty
  property p_done; in_valid && in_beat.eop |=> msg_done; endproperty
  property p_inv; msg_invalid && !(in_valid && in_beat.sop) |=> msg_invalid; endproperty
  a_hdr: assert property (p_hdr) else $error("header verdict without byte");
  a_ver: assert property (p_ver) else $error("send version wrong");
  a_id: assert property (p_id) else $error("full id not prefix plus suffix");
  a_le: assert property (p_le) else $error("byte order not flag 0");
  a_kf: assert property (p_kf) else $error("kind flags wrong");
  a_last: assert property (p_last) else $error("zero length not last");
  a_next: assert property (p_next) else $error("body length differs");
  a_body: assert property (p_body) else $error("body byte without input");
  a_done: assert property (p_done) else $error("no done after end");
  a_inv: assert property (p_inv) else $error("invalid dropped early");
  c_hdr: cover property (hdr_valid);
  c_last: cover property (part_valid && part_info.last);
  c_inv: cover property ($rose(msg_invalid));
endmodule
bind rmf_framer rmf_framer_chk chk (.*);
`default_nettype wire

// File: tb/rmf_remote_peer.sv
`default_nettype none
module rmf_remote_peer
  import rmf_pkg::*;
(
  // Link to the framer
  input wire logic clk,
  output logic in_valid,
  output rmf_beat_t in_beat,
  output logic [31:0] total_length
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    in_valid = 1'b0;
    in_beat = '0;
    total_length = '0;
  end
  // Length rides beside the bytes as the transport gives it
  // Idle beats carry inverted data, except that after a gapped send the final one repeats the last byte
  task automatic send(input logic [7:0] m[$], input int gap);
    for (int i = 0; i < m.size(); i++) begin
      @(posedge clk);
      in_valid <= 1'b1;
      in_beat <= '{data: m[i], sop: (i == 0), eop: (i == m.size() - 1)};
      total_length <= (i == 0) ? 32'(m.size()) : 32'hFFFF_FFFF;
      for (int g = 0; g < gap; g++) begin
        @(posedge clk);
        in_valid <= 1'b0;
        in_beat <= '{data: ~m[i], sop: 1'b0, eop: 1'b0};
      end
    end
    @(posedge clk);
    in_valid <= 1'b0;
    in_beat <= '{data: ~in_beat.data, sop: 1'b0, eop: 1'b0};
  endtask
endmodule
`default_nettype wire

// File: tb/tb_rmf_framer.sv
`default_nettype none
module tb_rmf_framer
  import rmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_b, in_valid, hdr_valid, hdr_bad, part_valid, part_skip, body_valid, msg_done, msg_invalid;
  rmf_beat_t in_beat;
  logic [31:0] total_length, entity_suffix;
  rmf_version_t source_version, current_protocol_version;
  logic [15:0] implementer_code;
  logic [95:0] default_id_prefix;
  logic [127:0] full_id;
  rmf_part_t part_info;
  logic [6:0] part_kind_flags;
  logic [7:0] body_data;
  logic [7:0] m[$];
  rmf_part_t pq[$];
  logic [6:0] kq[$];
  logic sq[$];
  logic [7:0] last_body;
  int n_hdr, n_bad, n_body, n_done, n_inv, cyc, fail_count, samples_checked;
  rmf_framer dut (.clk(clk), .rst_b(rst_b), .in_valid(in_valid), .in_beat(in_beat),
    .total_length(total_length), .hdr_valid(hdr_valid), .hdr_bad(hdr_bad), .source_version(source_version),
    .implementer_code(implementer_code), .default_id_prefix(default_id_prefix), .part_valid(part_valid),
    .part_info(part_info), .part_kind_flags(part_kind_flags), .part_skip(part_skip), .body_valid(body_valid),
    .body_data(body_data), .entity_suffix(entity_suffix), .full_id(full_id), .msg_done(msg_done),
    .msg_invalid(msg_invalid), .current_protocol_version(current_protocol_version));
  rmf_remote_peer rp (.clk(clk), .in_valid(in_valid), .in_beat(in_beat), .total_length(total_length));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (part_valid === 1'b1) pq.push_back(part_info);
    if (part_valid === 1'b1) kq.push_back(part_kind_flags);
    if (part_valid === 1'b1) sq.push_back(part_skip);
    if (body_valid === 1'b1) last_body = body_data;
    if (hdr_valid === 1'b1) n_hdr++;
    if (hdr_bad === 1'b1) n_bad++;
    if (body_valid === 1'b1) n_body++;
    if (msg_done === 1'b1) n_done++;
    if (msg_invalid === 1'b1) n_inv++;
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic add_hdr(input logic [7:0] id0, input logic [7:0] maj, input logic [15:0] ven);
    m = {id0, PROTO_ID_1, PROTO_ID_2, PROTO_ID_3, maj, VERSION_MINOR, ven[15:8], ven[7:0]};
    for (int i = 0; i < 12; i++) m.push_back(8'hA0 + 8'(i));
  endtask
  task automatic add_part(input logic [7:0] k, input logic [7:0] f, input logic [15:0] len, input int n);
    m = {m, k, f, f[0] ? len[7:0] : len[15:8], f[0] ? len[15:8] : len[7:0]};
    for (int i = 0; i < n; i++) m.push_back(8'h30 + 8'(i));
  endtask
  task automatic run(input int gap);
    {n_hdr, n_bad, n_body, n_done, n_inv} = '0;
    pq.delete();
    kq.delete();
    sq.delete();
    rp.send(m, gap);
    repeat (4) @(posedge clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    entity_suffix = 32'hC0DE_0001;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // Two parts, second little-endian and ending exactly at message end
    add_hdr(PROTO_ID_0, VERSION_MAJOR, 16'h0101);
    add_part(8'h15, 8'h00, 16'h0004, 4);
    add_part(8'h09, 8'h03, 16'h0008, 8);
    run(1);
    check(n_hdr, 1);
    check(implementer_code, 16'h0101);
    check(source_version, 16'h0202);
    check(default_id_prefix, 96'hA0A1A2A3A4A5A6A7A8A9AAAB);
    check(full_id, {96'hA0A1A2A3A4A5A6A7A8A9AAAB, 32'hC0DE_0001});
    check(current_protocol_version, 16'h0202);
    check(pq.size(), 2);
    check({pq[0].kind, pq[0].length, pq[0].last}, {8'h15, 16'h0004, 1'b0});
    check(pq[0].body_length, 4);
    check({pq[0].start_offset, pq[1].start_offset}, {32'd24, 32'd32});
    check({pq[1].little_endian, pq[1].length}, {1'b1, 16'h0008});
    check(pq[1].last, 1'b1);
    check(kq[1], 7'h01);
    check({n_body, last_body}, {32'd12, 8'h37});
    check({sq[0], sq[1]}, 2'b00);
    check({n_done, n_inv}, {32'd1, 32'd0});
    $display("test 1 done");
    // Unknown vendor, unknown kind, vendor kind, zero-length last part
    entity_suffix <= 32'h5EED_0002;
    add_hdr(PROTO_ID_0, VERSION_MAJOR, UNKNOWN_VENDOR_CODE);
    add_part(8'h30, 8'h00, 16'h0002, 2);
    add_part(8'h80, 8'h00, 16'h0002, 2);
    add_part(8'h07, 8'h00, 16'h0000, 6);
    run(0);
    check({n_hdr, implementer_code}, {32'd1, 16'h0000});
    check(full_id, {96'hA0A1A2A3A4A5A6A7A8A9AAAB, 32'h5EED_0002});
    check(pq.size(), 3);
    check(pq[0].known, 1'b0);
    check(pq[1].vendor, 1'b1);
    check({pq[2].last, pq[2].body_length}, {1'b1, 32'd6});
    check({sq[0], sq[1], sq[2], n_body}, {1'b1, 1'b1, 1'b0, 32'd6});
    check(n_inv, 0);
    $display("test 2 done");
    // Wrong identifier, then wrong major version
    for (int c = 0; c < 2; c++) begin
      add_hdr(c ? PROTO_ID_0 : 8'h00, c ? 8'h03 : VERSION_MAJOR, 16'h0101);
      add_part(8'h15, 8'h00, 16'h0000, 2);
      run(0);
      check({n_hdr, n_bad, 32'(pq.size())}, {32'd0, 32'd1, 32'd0});
    end
    $display("test 3 done");
    // Length past the end, then a cut-off part header
    for (int c = 0; c < 2; c++) begin
      add_hdr(PROTO_ID_0, VERSION_MAJOR, 16'h0101);
      if (c == 0) add_part(8'h15, 8'h00, 16'h0014, 4);
      else m = {m, 8'h15, 8'h00};
      run(0);
      check({n_inv > 0, 32'(pq.size())}, {1'b1, 32'd0});
    end
    $display("test 4 done");
    test_done();
  end
endmodule
`default_nettype wire
